// ==== shared/pcr_pkg.sv ====
// Package with register offsets, field positions, reset values and timing counts of the PLL bank.
package pcr_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFF_PUMP_STATUS = 10'h1B8;
  localparam logic [ADDR_W-1:0] OFF_SEQ_CTRL = 10'h1B9;
  localparam logic [ADDR_W-1:0] OFF_SEQ_STATE = 10'h1BA;
  localparam logic [ADDR_W-1:0] OFF_VCO_BIAS = 10'h1BB;
  localparam logic [ADDR_W-1:0] OFF_VCO_PRSC = 10'h1BC;
  localparam logic [ADDR_W-1:0] OFF_CAL_REF = 10'h1BD;
  localparam int BIT_CLK_HALVE = 7;
  localparam int BIT_DITHER = 6;
  localparam int BIT_SEQ_EN = 5;
  localparam int BIT_OFFSET_OFF = 4;
  localparam int BIT_OVERRIDE = 3;
  localparam int BIT_CAL_ON = 2;
  localparam int BIT_CMP = 6;
  localparam int BIT_DONE = 5;
  localparam int BIT_VCO_ACTIVE = 4;
  localparam int BIAS_W = 5;
  localparam int CALREF_W = 4;
  localparam logic [DATA_W-1:0] RST_SEQ_CTRL = 8'h34;
  localparam logic [3:0] RST_FORCED = 4'h0;
  localparam logic [BIAS_W-1:0] RST_VCO_BIAS = 5'h0C;
  localparam logic [DATA_W-1:0] RST_VCO_PRSC = 8'h00;
  localparam logic [CALREF_W-1:0] RST_CAL_REF = 4'h0;
  localparam int PUMP_SETTLE_CYC = 4;
  localparam int VCO_CAL_TICKS = 64;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_PCAL = 4'h2,
    ST_VCAL = 4'h4,
    ST_LOCK = 4'h8
  } pcr_state_e;
endpackage : pcr_pkg

// ==== shared/pcr_seq_if.sv ====
// Interface between the register bank and the power-up sequencing machine.
`timescale 1ns/1ps
interface pcr_seq_if;
  logic enable;
  logic cal_on;
  logic halve;
  logic cmp;
  logic [3:0] state;
  logic [3:0] trial;
  logic [3:0] result;
  logic done;
  logic vco_active;
  logic cal_tick;
  modport regs (output enable, output cal_on, output halve, output cmp,
    input state, input trial, input result, input done, input vco_active, input cal_tick);
  modport seq (input enable, input cal_on, input halve, input cmp,
    output state, output trial, output result, output done, output vco_active,
    output cal_tick);
endinterface : pcr_seq_if

// ==== rtl/pcr_seq.sv ====
// Power-up sequencing machine with charge-pump and VCO band calibration.
`timescale 1ns/1ps
module pcr_seq
  import pcr_pkg::*;
#(
  parameter int SETTLE_CYC = PUMP_SETTLE_CYC,
  parameter int VCO_TICKS = VCO_CAL_TICKS
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  pcr_seq_if.seq bus
);
  import pcr_pkg::*;

  pcr_state_e state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic [1:0] bit_q, bit_d;
  logic [3:0] trial_q, trial_d, result_q, result_d;
  logic done_q, done_d, tick_q;
  wire tick = bus.halve ? tick_q : 1'b1;
  wire settle_end = (cnt_q == 8'(SETTLE_CYC - 1));
  wire vco_end = tick && (cnt_q == 8'(VCO_TICKS - 1));
  wire [3:0] bit_mask = 4'(4'h1 << bit_q);
  wire [3:0] kept = bus.cmp ? trial_q : (trial_q & ~bit_mask);
  wire [3:0] next_bit = (bit_q == 2'h0) ? 4'h0 : 4'(bit_mask >> 1);

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    trial_d = trial_q;
    result_d = result_q;
    done_d = done_q;
    case (state_q)
      ST_IDLE:
      begin
        cnt_d = 8'h00;
        if (bus.enable && bus.cal_on)
        begin
          state_d = ST_PCAL;
          bit_d = 2'h3;
          trial_d = 4'h8;
          done_d = 1'b0;
        end
        else if (bus.enable)
          state_d = ST_VCAL;
      end
      ST_PCAL:
      begin
        cnt_d = settle_end ? 8'h00 : 8'(cnt_q + 8'h01);
        if (settle_end)
        begin
          trial_d = kept | next_bit;
          bit_d = 2'(bit_q - 2'h1);
          if (bit_q == 2'h0)
          begin
            result_d = kept;
            done_d = 1'b1;
            state_d = ST_VCAL;
          end
        end
      end
      ST_VCAL:
      begin
        if (tick)
          cnt_d = 8'(cnt_q + 8'h01);
        if (vco_end)
          state_d = ST_LOCK;
      end
      ST_LOCK: state_d = ST_LOCK;
      default: state_d = ST_IDLE;
    endcase
    if (!bus.enable)
      state_d = ST_IDLE;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 8'h00;
      bit_q <= 2'h3;
      trial_q <= 4'h8;
      result_q <= 4'h0;
      done_q <= 1'b0;
      tick_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      trial_q <= trial_d;
      result_q <= result_d;
      done_q <= done_d;
      tick_q <= (state_q == ST_VCAL) ? ~tick_q : 1'b0;
    end
  end

  assign bus.state = state_q;
  assign bus.trial = trial_q;
  assign bus.result = result_q;
  assign bus.done = done_q;
  assign bus.vco_active = (state_q == ST_VCAL);
  assign bus.cal_tick = (state_q == ST_VCAL) && tick;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence pcal_exit_s;
    state_q == ST_PCAL ##1 state_q == ST_VCAL;
  endsequence

  sequence halve_tick_s;
    bus.halve && bus.cal_tick ##1 bus.halve;
  endsequence

  seq_off_idle_a: assert property (!bus.enable |=> state_q == ST_IDLE)
    else $error("Machine left idle while disabled.");
  pcal_skip_a: assert property (state_q == ST_IDLE && bus.enable && !bus.cal_on
    |=> state_q == ST_VCAL)
    else $error("Pump calibration ran while suppressed.");
  done_after_pcal_a: assert property (pcal_exit_s |-> done_q)
    else $error("Done flag not set after pump calibration.");
  half_tick_a: assert property (halve_tick_s |-> !bus.cal_tick)
    else $error("Halved calibration clock ticked twice in a row.");
  vco_lock_a: assert property (state_q == ST_VCAL && vco_end && bus.enable
    |=> state_q == ST_LOCK)
    else $error("Machine did not lock after the last calibration tick.");
  result_hold_a: assert property (state_q == ST_LOCK |=> $stable(result_q))
    else $error("Stored trim result changed after calibration.");
endmodule : pcr_seq

// ==== rtl/pcr_regs.sv ====
// Register bank for PLL sequencing, charge-pump calibration and VCO trims.
`timescale 1ns/1ps
module pcr_regs
  import pcr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [pcr_pkg::ADDR_W-1:0] i_addr,
  input wire logic [pcr_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_pump_cmp,
  output logic [pcr_pkg::DATA_W-1:0] o_rdata,
  output logic [3:0] o_pump_trim,
  output logic o_cal_tick,
  output logic o_offset_off,
  output logic o_dither_mode,
  output logic [1:0] o_pump_test,
  output logic [pcr_pkg::BIAS_W-1:0] o_vco_bias_trim,
  output logic [pcr_pkg::DATA_W-1:0] o_vco_prsc_opts,
  output logic [pcr_pkg::CALREF_W-1:0] o_vco_cal_ref
);
  import pcr_pkg::*;

  pcr_seq_if sif ();
  logic [DATA_W-1:0] ctrl_q, prsc_q, rdata_q;
  logic [3:0] forced_q, trim_q;
  logic [BIAS_W-1:0] bias_q;
  logic [CALREF_W-1:0] calref_q;
  logic cmp_s1_q, cmp_s2_q, cmp_s3_q, cmp_q;

  wire wr_ctrl = i_wr_en && (i_addr == OFF_SEQ_CTRL);
  wire wr_state = i_wr_en && (i_addr == OFF_SEQ_STATE);
  wire wr_bias = i_wr_en && (i_addr == OFF_VCO_BIAS);
  wire wr_prsc = i_wr_en && (i_addr == OFF_VCO_PRSC);
  wire wr_calref = i_wr_en && (i_addr == OFF_CAL_REF);
  wire override = ctrl_q[BIT_OVERRIDE];
  wire pcal_busy = (sif.state == ST_PCAL);
  wire [3:0] trim_sel = pcal_busy ? sif.trial : (override ? forced_q : sif.result);
  wire [DATA_W-1:0] status_word = {1'b0, cmp_q, sif.done, sif.vco_active, sif.result};
  wire [DATA_W-1:0] rd_mux =
    (i_addr == OFF_PUMP_STATUS) ? status_word :
    (i_addr == OFF_SEQ_CTRL) ? ctrl_q :
    (i_addr == OFF_SEQ_STATE) ? {sif.state, forced_q} :
    (i_addr == OFF_VCO_BIAS) ? {3'h0, bias_q} :
    (i_addr == OFF_VCO_PRSC) ? prsc_q :
    (i_addr == OFF_CAL_REF) ? {4'h0, calref_q} : 8'h00;

  assign sif.enable = ctrl_q[BIT_SEQ_EN];
  assign sif.cal_on = ctrl_q[BIT_CAL_ON];
  assign sif.halve = ctrl_q[BIT_CLK_HALVE];
  assign sif.cmp = cmp_q;

  pcr_seq #(
    .SETTLE_CYC(PUMP_SETTLE_CYC),
    .VCO_TICKS(VCO_CAL_TICKS)
  ) u_seq (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .bus(sif.seq)
  );

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
      cmp_s3_q <= 1'b0;
      cmp_q <= 1'b0;
    end
    else
    begin
      cmp_s1_q <= i_pump_cmp;
      cmp_s2_q <= cmp_s1_q;
      cmp_s3_q <= cmp_s2_q;
      if (cmp_s2_q == cmp_s3_q)
        cmp_q <= cmp_s3_q;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ctrl_q <= RST_SEQ_CTRL;
      forced_q <= RST_FORCED;
      bias_q <= RST_VCO_BIAS;
      prsc_q <= RST_VCO_PRSC;
      calref_q <= RST_CAL_REF;
      rdata_q <= 8'h00;
      trim_q <= 4'h0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= i_wdata;
      if (wr_state)
        forced_q <= i_wdata[3:0];
      if (wr_bias)
        bias_q <= i_wdata[BIAS_W-1:0];
      if (wr_prsc)
        prsc_q <= i_wdata;
      if (wr_calref)
        calref_q <= i_wdata[CALREF_W-1:0];
      if (i_rd_en)
        rdata_q <= rd_mux;
      trim_q <= trim_sel;
    end
  end

  assign o_rdata = rdata_q;
  assign o_pump_trim = trim_q;
  assign o_cal_tick = sif.cal_tick;
  assign o_offset_off = ctrl_q[BIT_OFFSET_OFF];
  assign o_dither_mode = ctrl_q[BIT_DITHER];
  assign o_pump_test = ctrl_q[1:0];
  assign o_vco_bias_trim = bias_q;
  assign o_vco_prsc_opts = prsc_q;
  assign o_vco_cal_ref = calref_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  forced_trim_a: assert property (!pcal_busy && override |=> o_pump_trim == $past(forced_q))
    else $error("Forced trim code not driven to the pump.");
  auto_trim_a: assert property (!pcal_busy && !override |=> o_pump_trim == $past(sif.result))
    else $error("Calibrated trim result not driven to the pump.");
  state_read_a: assert property (i_rd_en && i_addr == OFF_SEQ_STATE
    |=> o_rdata[7:4] == $past(sif.state))
    else $error("Machine state readback mismatch.");
  pcal_trim_a: assert property (pcal_busy |=> o_pump_trim == $past(sif.trial))
    else $error("Trial code not driven to the pump during calibration.");
  status_read_a: assert property (i_rd_en && i_addr == OFF_PUMP_STATUS |=>
    o_rdata[BIT_DONE] == $past(sif.done) && o_rdata[3:0] == $past(sif.result))
    else $error("Calibration status readback mismatch.");
  rdata_hold_a: assert property (!i_rd_en |=> $stable(o_rdata))
    else $error("Read data changed without a read.");
  enable_reset_a: assert property (!$past(i_rst_n) |-> ctrl_q[BIT_SEQ_EN] && ctrl_q[BIT_CAL_ON])
    else $error("Machine or calibration enable not set after reset.");
endmodule : pcr_regs

// ==== test/pcr_regs_tb.sv ====
// Self-checking testbench for the PLL register bank and its sequencing machine.
`timescale 1ns/1ps
module testbench;
  import pcr_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0;
  logic i_pump_cmp = 1'b1;
  logic [DATA_W-1:0] o_rdata;
  logic [3:0] o_pump_trim;
  logic o_cal_tick;
  logic o_offset_off;
  logic o_dither_mode;
  logic [1:0] o_pump_test;
  logic [BIAS_W-1:0] o_vco_bias_trim;
  logic [DATA_W-1:0] o_vco_prsc_opts;
  logic [CALREF_W-1:0] o_vco_cal_ref;
  int miscompares = 0;
  int checks_done = 0;
  logic [7:0] rd;
  int n;

  pcr_regs u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_pump_cmp(i_pump_cmp), .o_rdata(o_rdata),
    .o_pump_trim(o_pump_trim), .o_cal_tick(o_cal_tick), .o_offset_off(o_offset_off),
    .o_dither_mode(o_dither_mode), .o_pump_test(o_pump_test),
    .o_vco_bias_trim(o_vco_bias_trim), .o_vco_prsc_opts(o_vco_prsc_opts),
    .o_vco_cal_ref(o_vco_cal_ref));

  always #12.5 i_clk = ~i_clk;

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr_en <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr_en <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [ADDR_W-1:0] a);
    @(posedge i_clk);
    i_rd_en <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd_en <= 1'b0;
    #1;
    rd = o_rdata;
  endtask : rdr

  task automatic wait_done();
    int k;
    k = 0;
    rdr(OFF_PUMP_STATUS);
    while (rd[BIT_DONE] !== 1'b1 && k < 100)
    begin
      rdr(OFF_PUMP_STATUS);
      k++;
    end
    chk("done flag", 8'h01, {7'h00, rd[BIT_DONE]});
  endtask : wait_done

  task automatic count_ticks();
    n = 0;
    repeat (8)
    begin
      @(posedge i_clk);
      #1;
      if (o_cal_tick === 1'b1)
        n++;
    end
  endtask : count_ticks

  task automatic t_reset_and_regs();
    rdr(OFF_SEQ_CTRL);
    chk("ctrl reset", 8'h34, rd);
    chk("offset off", 8'h01, {7'h00, o_offset_off});
    chk("test reset", 8'h00, {6'h00, o_pump_test});
    chk("dither reset", 8'h00, {7'h00, o_dither_mode});
    rdr(OFF_CAL_REF);
    chk("calref reset", 8'h00, rd);
    wr(OFF_CAL_REF, 8'hFF);
    rdr(OFF_CAL_REF);
    chk("calref rw", 8'h0F, rd);
    chk("calref out", 8'h0F, {4'h0, o_vco_cal_ref});
    rdr(OFF_VCO_BIAS);
    chk("bias reset", 8'h0C, rd);
    rdr(OFF_VCO_PRSC);
    chk("prsc reset", 8'h00, rd);
    wr(OFF_VCO_BIAS, 8'hFF);
    rdr(OFF_VCO_BIAS);
    chk("bias rw", 8'h1F, rd);
    chk("bias out", 8'h1F, {3'h0, o_vco_bias_trim});
    wr(OFF_VCO_PRSC, 8'hA5);
    rdr(OFF_VCO_PRSC);
    chk("prsc rw", 8'hA5, rd);
    chk("prsc out", 8'hA5, o_vco_prsc_opts);
    rdr(10'h000);
    chk("unmapped", 8'h00, rd);
    $display("test reset_and_regs done");
  endtask : t_reset_and_regs

  task automatic t_first_cal();
    wait_done();
    chk("status", 8'h6F, rd & 8'hEF);
    chk("trim auto", 8'h0F, {4'h0, o_pump_trim});
    $display("test first_cal done");
  endtask : t_first_cal

  task automatic t_vco_halve();
    wr(OFF_SEQ_CTRL, 8'h57);
    repeat (3) @(posedge i_clk);
    rdr(OFF_SEQ_STATE);
    chk("idle state", 8'h01, {4'h0, rd[7:4]});
    chk("dither", 8'h01, {7'h00, o_dither_mode});
    chk("pump test", 8'h03, {6'h00, o_pump_test});
    wr(OFF_SEQ_CTRL, 8'h30);
    repeat (3) @(posedge i_clk);
    count_ticks();
    chk("ticks full", 8'h08, n[7:0]);
    rdr(OFF_PUMP_STATUS);
    chk("vco active", 8'h3F, rd & 8'h3F);
    wr(OFF_SEQ_CTRL, 8'h14);
    wr(OFF_SEQ_CTRL, 8'hB0);
    repeat (3) @(posedge i_clk);
    count_ticks();
    chk("ticks half", 8'h04, n[7:0]);
    rdr(OFF_SEQ_STATE);
    chk("vcal state", 8'h04, {4'h0, rd[7:4]});
    $display("test vco_halve done");
  endtask : t_vco_halve

  task automatic t_recal_override();
    @(posedge i_clk);
    i_pump_cmp <= 1'b0;
    wr(OFF_SEQ_CTRL, 8'h14);
    repeat (6) @(posedge i_clk);
    wr(OFF_SEQ_CTRL, 8'h34);
    repeat (2) @(posedge i_clk);
    wait_done();
    chk("result zero", 8'h00, rd & 8'h0F);
    repeat (2) @(posedge i_clk);
    chk("trim zero", 8'h00, {4'h0, o_pump_trim});
    wr(OFF_SEQ_STATE, 8'h05);
    wr(OFF_SEQ_CTRL, 8'h3C);
    repeat (3) @(posedge i_clk);
    chk("trim forced", 8'h05, {4'h0, o_pump_trim});
    rdr(OFF_SEQ_STATE);
    chk("forced rb", 8'h05, rd & 8'h0F);
    wr(OFF_SEQ_CTRL, 8'h34);
    repeat (3) @(posedge i_clk);
    chk("trim back", 8'h00, {4'h0, o_pump_trim});
    $display("test recal_override done");
  endtask : t_recal_override

  task automatic t_vco_lock();
    repeat (60) @(posedge i_clk);
    rdr(OFF_SEQ_STATE);
    chk("lock state", 8'h08, {4'h0, rd[7:4]});
    rdr(OFF_PUMP_STATUS);
    chk("lock status", 8'h20, rd & 8'h3F);
    chk("lock trim", 8'h00, {4'h0, o_pump_trim});
    $display("test vco_lock done");
  endtask : t_vco_lock

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  initial
  begin
    #200000;
    miscompares++;
    final_report();
  end

  initial
  begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset_and_regs();
    t_first_cal();
    t_vco_halve();
    t_recal_override();
    t_vco_lock();
    final_report();
  end
endmodule : testbench
